// >>> rtl/epb_core.sv
/*
 * Emulation pod external bus behaviour: run/halt tracking, bus pin
 * control per access area, interrupt and hold gating, reserved vectors,
 * software breaks, write-protect and pull-up control.
 * Assumes all inputs are synchronous to core_clk; the data bus is split
 * into input, output and enable, the wire is resolved outside.
 */
// Summary of operation
// - Software break fetch returns opcode 00.
// - No software break in external map.
// - Accept NMI only while running.
// - Step onto match halts after return.
// - Debugger-set protect bit stays protected.
// - Pull-ups live only for groups 6-10.
// - Pod oscillator runs through stop.
// - Low port hold lags 3 cycles (2.5 rounded up).
// - Reserved vectors hide downloaded data.
// - SFR access in run: no strobes, ALE pulses.
// - Stop: hold address, strobes high.
// - Wait: hold address, strobes high.
// - Halted: drive read strobe, write high.
`timescale 1ns/1ns
module epb_core
    import epb_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic go_cmd,
    input wire logic halt_cmd,
    input wire logic step_cmd,
    input wire logic stop_enter,
    input wire logic wait_enter,
    input wire logic wake,
    input wire logic match_irq_entry,
    input wire logic match_irq_return,
    input wire logic insn_done,
    input wire logic access_valid,
    input wire logic access_write,
    input wire logic access_fetch,
    input wire logic [AW-1:0] access_addr,
    input wire logic access_upper,
    input wire logic [DW-1:0] access_wdata,
    input wire logic map_external_attr,
    input wire logic map_sfr,
    input wire logic [DW-1:0] mem_rdata,
    input wire logic soft_break_hit,
    input wire logic sw_break_arm,
    input wire logic [DW-1:0] data_in,
    input wire logic nmi_n,
    input wire logic hold_n,
    input wire logic pod_osc_sel,
    input wire logic core_clk_gate_req,
    input wire logic protect_set,
    input wire logic protect_set_debug,
    input wire logic protect_use,
    input wire logic pull_wr,
    input wire logic [PORT_GROUPS-1:0] pull_wdata,
    output logic running,
    output logic nmi_accept,
    output logic hold_low_ports,
    output logic hold_high_ports,
    output logic osc_run,
    output logic port_serial_write_protect,
    output logic protect_write_ok,
    output logic [DW-1:0] read_data,
    output logic sw_break_taken,
    output logic [AW-1:0] addr_out,
    output logic upper_byte_strobe_n,
    output logic [DW-1:0] data_out,
    output logic data_oe,
    output logic rd_n,
    output logic wr_n,
    output logic cs_n,
    output logic ale,
    output logic [PORT_GROUPS-1:0] pull_rdata,
    output logic [PORT_GROUPS-1:0] pull_enable
);
    epb_state_t state;
    epb_state_t next_state;
    logic hold_gated;
    logic hold_arrived;
    logic step_pending;
    logic isr_seen;
    logic protect_clean;

    // Run/halt state.
    always_comb begin
        next_state = state;
        unique case (state)
            EPB_HALTED: begin
                if (go_cmd) next_state = EPB_RUN;
                else if (step_cmd) next_state = EPB_RUN;
            end
            EPB_RUN: begin
                if (halt_cmd) next_state = EPB_HALTED;
                else if (step_pending && match_irq_entry) next_state = EPB_STEP_ISR;
                else if (step_pending && insn_done) next_state = EPB_HALTED;
                else if (stop_enter) next_state = EPB_STOP;
                else if (wait_enter) next_state = EPB_WAIT;
            end
            EPB_STOP, EPB_WAIT: begin
                if (halt_cmd) next_state = EPB_HALTED;
                else if (wake) next_state = EPB_RUN;
            end
            EPB_STEP_ISR: begin
                if (halt_cmd) next_state = EPB_HALTED;
                else if (isr_seen && insn_done) next_state = EPB_HALTED;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state <= EPB_HALTED;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            step_pending <= 1'b0;
            isr_seen <= 1'b0;
        end else begin
            if (state == EPB_HALTED && step_cmd && !go_cmd) step_pending <= 1'b1;
            else if (next_state == EPB_HALTED) step_pending <= 1'b0;
            if (state != EPB_STEP_ISR) isr_seen <= 1'b0;
            else if (match_irq_return) isr_seen <= 1'b1;
        end
    end

    assign running = (state != EPB_HALTED);

    // Target interrupt and hold only count while the program executes.
    assign nmi_accept = running && !nmi_n;
    assign hold_gated = running && !hold_n;
    assign hold_high_ports = hold_gated;

    epb_hold_delay u_hold_delay (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .hold_in(hold_gated),
        .hold_out(hold_arrived)
    );
    assign hold_low_ports = hold_arrived && hold_gated;

    // Pod oscillator ignores the stop-mode gate.
    assign osc_run = pod_osc_sel || !core_clk_gate_req;

    // Protect bit: only a clean run-time set releases protection.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            port_serial_write_protect <= 1'b0;
            protect_clean <= 1'b0;
        end else begin
            if (protect_set || protect_set_debug) port_serial_write_protect <= 1'b1;
            else if (protect_use) port_serial_write_protect <= 1'b0;
            // A window set, a step or any halt before use keeps the protection.
            if (protect_set_debug) begin
                protect_clean <= 1'b0;
            end else if (protect_set) begin
                protect_clean <= (state == EPB_RUN) && !step_pending && !halt_cmd;
            end else if (halt_cmd || !running || protect_use) begin
                protect_clean <= 1'b0;
            end
        end
    end
    assign protect_write_ok = port_serial_write_protect && protect_clean;

    // Read path: reserved vectors and software break substitution.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            read_data <= '0;
            sw_break_taken <= 1'b0;
        end else begin
            sw_break_taken <= 1'b0;
            if (access_valid && !access_write) begin
                if (epb_is_reserved_vec(access_addr)) begin
                    read_data <= VEC_FILL;
                end else if (access_fetch && soft_break_hit && sw_break_arm
                             && !map_external_attr && running) begin
                    read_data <= {{(DW-8){1'b0}}, BREAK_OPCODE};
                    sw_break_taken <= 1'b1;
                end else if (map_external_attr) begin
                    read_data <= data_in;
                end else begin
                    read_data <= mem_rdata;
                end
            end
        end
    end

    // External bus pins.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            addr_out <= '0;
            upper_byte_strobe_n <= 1'b1;
            data_out <= '0;
            data_oe <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            cs_n <= 1'b1;
            ale <= 1'b0;
        end else begin
            unique case (state)
                EPB_STOP, EPB_WAIT: begin
                    data_oe <= 1'b0;
                    rd_n <= 1'b1;
                    wr_n <= 1'b1;
                    ale <= 1'b1;
                end
                EPB_HALTED: begin
                    data_oe <= 1'b0;
                    wr_n <= 1'b1;
                    if (access_valid) begin
                        addr_out <= access_addr;
                        upper_byte_strobe_n <= !access_upper;
                    end
                    rd_n <= !(access_valid && !access_write);
                    cs_n <= !(access_valid && map_external_attr);
                    ale <= access_valid;
                end
                EPB_RUN, EPB_STEP_ISR: begin
                    ale <= access_valid;
                    if (access_valid) begin
                        addr_out <= access_addr;
                        upper_byte_strobe_n <= !access_upper;
                    end
                    if (access_valid && map_external_attr && !map_sfr) begin
                        data_out <= access_wdata;
                        data_oe <= access_write;
                        rd_n <= access_write;
                        wr_n <= !access_write;
                        cs_n <= 1'b0;
                    end else begin
                        data_oe <= 1'b0;
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        cs_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    epb_pullup u_pullup (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pull_wr(pull_wr),
        .pull_wdata(pull_wdata),
        .pull_rdata(pull_rdata),
        .pull_enable(pull_enable)
    );

    sequence sfr_access_s;
        access_valid && map_sfr && state == EPB_RUN;
    endsequence

    // Program-run bus cycles that reach the board as a real external access.
    sequence ext_cycle_s;
        access_valid && map_external_attr && !map_sfr
            && (state == EPB_RUN || state == EPB_STEP_ISR);
    endsequence

    // A run-time fetch from pod memory that hits an armed software break.
    sequence soft_break_fetch_s;
        access_valid && !access_write && access_fetch && soft_break_hit && sw_break_arm
            && !map_external_attr && running && !epb_is_reserved_vec(access_addr);
    endsequence

    nmi_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !running |-> !nmi_accept) else $error("nmi accepted while halted");
    sfr_bus_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        sfr_access_s |=> ale && rd_n && wr_n && cs_n && !data_oe)
        else $error("sfr access drove strobes");
    stop_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == EPB_STOP && $past(state) == EPB_STOP
        |=> $stable(addr_out) && $stable(cs_n) && ale && rd_n && wr_n && !data_oe)
        else $error("stop mode bus not held");
    wait_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == EPB_WAIT |=> $stable(addr_out) && $stable(upper_byte_strobe_n)
        && $stable(cs_n) && ale && rd_n && wr_n && !data_oe)
        else $error("wait mode bus active");
    halt_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == EPB_HALTED |=> wr_n && !data_oe) else $error("write while halted");
    halt_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == EPB_HALTED && access_valid && !access_write |=> !rd_n && ale)
        else $error("halted read strobe missing");
    int_area_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        access_valid && !map_external_attr && (state == EPB_RUN || state == EPB_STEP_ISR)
        |=> ale && rd_n && wr_n && cs_n && !data_oe)
        else $error("internal access drove strobes");
    ext_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        ext_cycle_s ##0 access_write |=> !wr_n && rd_n && !cs_n && data_oe && ale)
        else $error("external write strobes missing");
    vec_hide_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        access_valid && !access_write && epb_is_reserved_vec(access_addr)
        |=> read_data == VEC_FILL) else $error("reserved vector exposed");
    ext_break_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        access_valid && map_external_attr |=> !sw_break_taken)
        else $error("software break in external area");
    break_sub_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        soft_break_fetch_s |=> sw_break_taken && read_data[7:0] == BREAK_OPCODE)
        else $error("software break not substituted");
    osc_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pod_osc_sel |-> osc_run) else $error("pod oscillator stopped");
    hold_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !running |-> !hold_high_ports && !hold_low_ports)
        else $error("hold taken while halted");
    step_isr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state == EPB_STEP_ISR && !isr_seen && !halt_cmd |=> state != EPB_HALTED)
        else $error("step halted inside handler");
    protect_dbg_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        protect_set_debug |=> !protect_write_ok) else $error("debugger set released");
endmodule

// >>> rtl/epb_hold_delay.sv
/*
 * Delays the hold acceptance for emulated port groups 0 to 5.
 * Assumes the hold request is already gated by run state.
 */
`timescale 1ns/1ns
module epb_hold_delay
    import epb_pkg::*;
#(
    parameter int DELAY = HOLD_EXTRA_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hold_in,
    output logic hold_out
);
    logic [DELAY-1:0] pipe;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pipe <= '0;
        end else begin
            pipe <= {pipe[DELAY-2:0], hold_in};
        end
    end

    assign hold_out = pipe[DELAY-1];

    hold_lag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        hold_in |-> ##3 hold_out) else $error("hold not delayed by three cycles");
endmodule

// >>> rtl/epb_pkg.sv
/*
 * Shared constants for the emulation pod bus behaviour block.
 * Assumes a single 20 MHz core clock and synchronous active-low reset.
 */
package epb_pkg;
    localparam int CLK_MHZ = 20;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam logic [7:0] BREAK_OPCODE = 8'h00;
    localparam logic [19:0] VEC_DEBUG_LO = 20'hFFFF4;
    localparam logic [19:0] VEC_STEP_LO = 20'hFFFEC;
    localparam logic [19:0] VEC_BREAK_LO = 20'hFFFE4;
    localparam logic [19:0] VEC_SPAN_MASK = 20'hFFFFC;
    localparam logic [15:0] VEC_FILL = 16'hFFFF;
    // Extra hold latency is 2.5 cycles; counted in half cycles, rounded up to 3 edges.
    localparam int HOLD_EXTRA_HALF = 5;
    localparam int HOLD_EXTRA_CYC = (HOLD_EXTRA_HALF + 1) / 2;
    localparam int PORT_GROUPS = 11;
    localparam int PULL_FIRST_LIVE = 6;
    localparam logic [10:0] PULL_LIVE_MASK = 11'h7C0;

    typedef enum logic [1:0] {
        EPB_AREA_SFR,
        EPB_AREA_INT,
        EPB_AREA_EXT
    } epb_area_t;

    typedef enum logic [2:0] {
        EPB_HALTED,
        EPB_RUN,
        EPB_STOP,
        EPB_WAIT,
        EPB_STEP_ISR
    } epb_state_t;

    function automatic logic epb_is_reserved_vec(input logic [19:0] a);
        logic [19:0] base;
        base = a & VEC_SPAN_MASK;
        return (base == VEC_DEBUG_LO) || (base == VEC_STEP_LO) || (base == VEC_BREAK_LO);
    endfunction
endpackage

// >>> rtl/epb_pullup.sv
/*
 * Pull-up control register for all port groups.
 * Assumes writes are single-cycle strobes from the core.
 */
`timescale 1ns/1ns
module epb_pullup
    import epb_pkg::*;
#(
    parameter int GROUPS = PORT_GROUPS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic pull_wr,
    input wire logic [GROUPS-1:0] pull_wdata,
    output logic [GROUPS-1:0] pull_rdata,
    output logic [GROUPS-1:0] pull_enable
);
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pull_rdata <= '0;
        end else if (pull_wr) begin
            pull_rdata <= pull_wdata;
        end
    end

    // Only the groups wired to real pull-ups respond.
    assign pull_enable = pull_rdata & PULL_LIVE_MASK;

    pull_mask_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pull_enable[5:0] == 6'h00) else $error("low groups pulled up");
    pull_store_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pull_wr |=> pull_rdata == $past(pull_wdata)) else $error("pull register lost");
endmodule

// >>> tb/epb_target_model.sv
/*
 * Behavioural model of the target board facing the emulation pod.
 * Assumes the bench requests interrupt and hold through req_nmi and req_hold.
 */
`timescale 1ns/1ns
module epb_target_model
    import epb_pkg::*;
#(
    parameter logic [15:0] READ_PAT = 16'hC3A5
) (
    input wire logic core_clk,
    input wire logic running,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic req_nmi,
    input wire logic req_hold,
    output logic nmi_n,
    output logic hold_n,
    output logic [15:0] data_in
);
    assign nmi_n = !req_nmi;
    // The board only requests the bus while the user program runs.
    assign hold_n = !(req_hold && running);
    initial data_in = 16'h0000;
    // Outside a selected read the bus is undriven, so show a changing pattern.
    always @(posedge core_clk) begin
        if (!cs_n && !rd_n) begin
            data_in <= READ_PAT;
        end else begin
            data_in <= ~data_in;
        end
    end
endmodule

// >>> tb/tb.sv
/*
 * Self-checking bench for the emulation pod bus block.
 * Assumes the target model on the far side; inputs change on falling edges.
 */
`timescale 1ns/1ns
module tb;
    import epb_pkg::*;
    logic core_clk, reset_n, go_cmd, halt_cmd, step_cmd, stop_enter, wait_enter, wake;
    logic match_irq_entry, match_irq_return, insn_done, access_valid, access_write;
    logic access_fetch, access_upper, map_external_attr, map_sfr, soft_break_hit;
    logic sw_break_arm, nmi_n, hold_n, pod_osc_sel, core_clk_gate_req, protect_set;
    logic protect_set_debug, protect_use, pull_wr, req_nmi, req_hold;
    logic [19:0] access_addr, addr_out;
    logic [15:0] access_wdata, mem_rdata, data_in, read_data, data_out;
    logic [10:0] pull_wdata, pull_rdata, pull_enable;
    logic running, nmi_accept, hold_low_ports, hold_high_ports, osc_run, upper_byte_strobe_n;
    logic port_serial_write_protect, protect_write_ok, sw_break_taken, data_oe;
    logic rd_n, wr_n, cs_n, ale;
    int failures = 0;
    int num_checks = 0;
    logic [19:0] vec [3] = '{VEC_DEBUG_LO, VEC_STEP_LO, VEC_BREAK_LO};

    epb_core i_epb_core (.core_clk(core_clk), .reset_n(reset_n), .go_cmd(go_cmd),
        .halt_cmd(halt_cmd), .step_cmd(step_cmd), .stop_enter(stop_enter),
        .wait_enter(wait_enter), .wake(wake), .match_irq_entry(match_irq_entry),
        .match_irq_return(match_irq_return), .insn_done(insn_done),
        .access_valid(access_valid), .access_write(access_write),
        .access_fetch(access_fetch), .access_addr(access_addr), .access_upper(access_upper),
        .access_wdata(access_wdata), .map_external_attr(map_external_attr), .map_sfr(map_sfr),
        .mem_rdata(mem_rdata), .soft_break_hit(soft_break_hit), .sw_break_arm(sw_break_arm),
        .data_in(data_in), .nmi_n(nmi_n), .hold_n(hold_n), .pod_osc_sel(pod_osc_sel),
        .core_clk_gate_req(core_clk_gate_req), .protect_set(protect_set),
        .protect_set_debug(protect_set_debug), .protect_use(protect_use), .pull_wr(pull_wr),
        .pull_wdata(pull_wdata), .running(running), .nmi_accept(nmi_accept),
        .hold_low_ports(hold_low_ports), .hold_high_ports(hold_high_ports),
        .osc_run(osc_run), .port_serial_write_protect(port_serial_write_protect),
        .protect_write_ok(protect_write_ok), .read_data(read_data),
        .sw_break_taken(sw_break_taken), .addr_out(addr_out),
        .upper_byte_strobe_n(upper_byte_strobe_n), .data_out(data_out), .data_oe(data_oe),
        .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .ale(ale), .pull_rdata(pull_rdata),
        .pull_enable(pull_enable));

    epb_target_model i_epb_target_model (.core_clk(core_clk), .running(running),
        .cs_n(cs_n), .rd_n(rd_n), .req_nmi(req_nmi), .req_hold(req_hold), .nmi_n(nmi_n),
        .hold_n(hold_n), .data_in(data_in));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic pulse(ref logic s);
        cyc(1);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus access; the registered pins are settled when it returns.
    task automatic acc(input logic w, f, ext, sfr, input logic [19:0] a,
            input logic [15:0] d);
        cyc(1);
        access_valid = 1'b1;
        access_write = w;
        access_fetch = f;
        map_external_attr = ext;
        map_sfr = sfr;
        access_addr = a;
        access_wdata = d;
        cyc(1);
        access_valid = 1'b0;
    endtask

    task automatic complete_run();
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        cyc(3000);
        failures++;
        complete_run();
    end

    initial begin
        {go_cmd, halt_cmd, step_cmd, stop_enter, wait_enter, wake} = '0;
        {match_irq_entry, match_irq_return, insn_done, access_valid, access_write} = '0;
        {access_fetch, access_upper, map_external_attr, map_sfr, soft_break_hit} = '0;
        {sw_break_arm, pod_osc_sel, core_clk_gate_req, protect_set} = '0;
        {protect_set_debug, protect_use, pull_wr, req_nmi, req_hold} = '0;
        access_addr = '0;
        access_wdata = '0;
        mem_rdata = 16'h1234;
        pull_wdata = '0;
        reset_n = 1'b0;
        cyc(16);
        reset_n = 1'b1;
        chk(running, 0);
        chk(rd_n, 1);
        chk(wr_n, 1);
        chk(ale, 0);
        chk(data_oe, 0);
        chk(pull_rdata, 0);
        req_nmi = 1'b1;
        cyc(1);
        chk(nmi_accept, 0);
        req_nmi = 1'b0;
        pulse(go_cmd);
        chk(running, 1);
        req_nmi = 1'b1;
        cyc(1);
        chk(nmi_accept, 1);
        req_nmi = 1'b0;
        req_hold = 1'b1;
        #1 chk(hold_high_ports, 1);
        cyc(2);
        chk(hold_low_ports, 0);
        cyc(1);
        chk(hold_low_ports, 1);
        req_hold = 1'b0;
        access_upper = 1'b1;
        acc(0, 0, 1, 1, 20'h003A0, 16'h0000);
        chk(addr_out, 20'h003A0);
        chk(upper_byte_strobe_n, 0);
        chk({ale, rd_n, wr_n, cs_n, data_oe}, 5'h1E);
        access_upper = 1'b0;
        acc(1, 0, 0, 0, 20'h00400, 16'hA5A5);
        chk({ale, rd_n, wr_n, cs_n, data_oe}, 5'h1E);
        acc(1, 0, 1, 0, 20'h80000, 16'h5AC3);
        chk({rd_n, wr_n, cs_n, data_oe}, 4'h9);
        chk(data_out, 16'h5AC3);
        acc(0, 0, 0, 0, 20'h00400, 16'h0000);
        chk(read_data, mem_rdata);
        for (int i = 0; i < 3; i++) begin
            acc(0, 0, 0, 0, vec[i] + 20'h00002, 16'h0000);
            chk(read_data, VEC_FILL);
        end
        sw_break_arm = 1'b1;
        soft_break_hit = 1'b1;
        acc(0, 1, 0, 0, 20'h00500, 16'h0000);
        chk(sw_break_taken, 1);
        chk(read_data, {8'h00, BREAK_OPCODE});
        acc(0, 1, 1, 0, 20'h80010, 16'h0000);
        chk(sw_break_taken, 0);
        sw_break_arm = 1'b0;
        soft_break_hit = 1'b0;
        acc(1, 0, 1, 0, 20'h81234, 16'h1111);
        pod_osc_sel = 1'b1;
        core_clk_gate_req = 1'b1;
        pulse(stop_enter);
        cyc(1);
        chk(addr_out, 20'h81234);
        chk({ale, rd_n, wr_n, cs_n, data_oe}, 5'h1E);
        chk(osc_run, 1);
        pulse(wake);
        pulse(wait_enter);
        cyc(1);
        chk(addr_out, 20'h81234);
        chk({ale, rd_n, wr_n, cs_n, data_oe}, 5'h1E);
        pulse(wake);
        core_clk_gate_req = 1'b0;
        pulse(protect_set);
        protect_use = 1'b1;
        #1 chk(protect_write_ok, 1);
        cyc(1);
        protect_use = 1'b0;
        pulse(protect_set);
        pulse(halt_cmd);
        chk(running, 0);
        protect_use = 1'b1;
        #1 chk(protect_write_ok, 0);
        cyc(1);
        protect_use = 1'b0;
        pulse(protect_set_debug);
        protect_use = 1'b1;
        #1 chk(protect_write_ok, 0);
        cyc(1);
        protect_use = 1'b0;
        acc(1, 0, 1, 0, 20'h82000, 16'h7777);
        chk({wr_n, cs_n, data_oe}, 3'h4);
        acc(0, 0, 1, 0, 20'h82002, 16'h0000);
        chk({ale, rd_n, wr_n}, 3'h5);
        chk(addr_out, 20'h82002);
        pull_wdata = 11'h7FF;
        pulse(pull_wr);
        chk(pull_rdata, 11'h7FF);
        chk(pull_enable, PULL_LIVE_MASK);
        pull_wdata = 11'h03F;
        pulse(pull_wr);
        chk(pull_rdata, 11'h03F);
        chk(pull_enable, 11'h000);
        pulse(step_cmd);
        pulse(protect_set);
        protect_use = 1'b1;
        #1 chk(protect_write_ok, 0);
        cyc(1);
        protect_use = 1'b0;
        pulse(match_irq_entry);
        pulse(insn_done);
        chk(running, 1);
        pulse(match_irq_return);
        pulse(insn_done);
        chk(running, 0);
        complete_run();
    end
endmodule
